// file: core/ftb_fifo.sv
`timescale 1ns/1ps
module ftb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] wr_d;
    logic [PW-1:0] rd_q;
    logic [PW-1:0] rd_d;
    logic [PW:0] count_q;
    logic [PW:0] count_d;
    logic push;
    logic pop;

    always_comb begin
        in_ready = (count_q != FULL_COUNT);
        out_valid = (count_q != '0);
        out_data = store[rd_q];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = wr_q;
        rd_d = rd_q;
        count_d = count_q;
        if (push) begin
            wr_d = (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            count_q <= count_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_q] <= in_data;
        end
    end

endmodule

// file: core/ftb_port.sv
// How it works
// - qualifier high: edge ignored, state held except output enable drive
// - selected, strobe high, load low: read begins
// - read word presented right after address edge
// - new operation accepted on every next edge
// - any select off with load: deselect, release
// - deselect releases lines after that edge
// - two-bit burst counter wraps, no carry
// - order low linear, high interleaved xor
// - advance ignores selects and write strobe
// - write strobe captured only on load
// - burst repeats type of previous access
// - selected, strobe low: write begins, captured
// - no drive during write data phase
// - write data taken on following edge
// - active-low lane selects gate each byte
// - unselected lanes keep stored contents
// - read leaving deselect drives from its first clock
// - starts deselected with lines released
// - order defaults interleaved, held constant
`timescale 1ns/1ps
module ftb_port #(
    parameter int ADDR_W = ftb_pkg::ADDR_W,
    parameter int FIFO_DEPTH = ftb_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clock_qualifier_n,
    input wire logic chip_select_a_n,
    input wire logic chip_select_b,
    input wire logic chip_select_c_n,
    input wire logic advance_load_n,
    input wire logic write_n,
    input wire logic [ftb_pkg::LANES-1:0] byte_lane_select_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic output_enable_n,
    input wire logic burst_order,
    input wire logic [ftb_pkg::DATA_W-1:0] data_in,
    output logic [ftb_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [ftb_pkg::LANES-1:0] parity_lines_in,
    output logic [ftb_pkg::LANES-1:0] parity_lines_out,
    output logic parity_lines_oe
);

    localparam int WORDS = 1 << ADDR_W;
    localparam int DW = ftb_pkg::DATA_W;
    localparam int LN = ftb_pkg::LANES;
    localparam int LW = ftb_pkg::LANE_W;
    localparam int BW = ftb_pkg::BURST_W;
    localparam int WW = ftb_pkg::WORD_W;
    localparam int EW = ADDR_W + DW + 2 * LN;

    // stored word: parity in the top bits, data below
    wire logic [WW-1:0] array_word;

    ftb_pkg::ftb_op_t op_q;
    ftb_pkg::ftb_op_t op_d;
    logic [ADDR_W-1:0] base_q;
    logic [ADDR_W-1:0] base_d;
    logic [BW-1:0] step_q;
    logic [BW-1:0] step_d;
    logic pend_q;
    logic pend_d;
    logic [ADDR_W-1:0] pend_addr_q;
    logic [ADDR_W-1:0] pend_addr_d;
    logic [LN-1:0] pend_lane_q;
    logic [LN-1:0] pend_lane_d;
    logic rd_q;
    logic rd_d;
    logic [WW-1:0] rdata_q;
    logic [WW-1:0] rdata_d;
    logic drive_q;
    logic drive_d;

    logic oe_n_sync;
    logic order_sync;
    logic selected;
    logic recognized;
    logic load;
    logic advance;
    logic access;
    logic [BW-1:0] next_step;
    logic [ADDR_W-1:0] acc_addr;
    logic [WW-1:0] merged;

    ftb_pkg::ftb_wr_t push_entry;
    ftb_pkg::ftb_wr_t head_entry;
    logic [EW-1:0] head_bits;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;

    // enable and order pins are asynchronous to clk
    ftb_sync #(
        .W(2),
        .RESET_VAL({ftb_pkg::OE_N_RESET, ftb_pkg::ORDER_RESET})
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({output_enable_n, burst_order}),
        .q({oe_n_sync, order_sync})
    );

    // completed writes queue here on their way into the array
    ftb_fifo #(
        .WIDTH(EW),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(push_entry),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(head_bits)
    );

    assign head_entry = head_bits;

    function automatic logic [BW-1:0] burst_low(
        input logic [BW-1:0] start,
        input logic [BW-1:0] step,
        input logic interleaved
    );
        logic [BW-1:0] r;
        r = start + step;
        if (interleaved) begin
            r = start ^ step;
        end
        return r;
    endfunction

    // overlay the selected lanes of a pending write onto a word
    function automatic logic [WW-1:0] lane_merge(
        input logic [WW-1:0] word,
        input logic [DW-1:0] data,
        input logic [LN-1:0] par,
        input logic [LN-1:0] lane_n
    );
        logic [WW-1:0] r;
        r = word;
        for (int l = 0; l < LN; l++) begin
            if (!lane_n[l]) begin
                r[l*LW +: LW] = data[l*LW +: LW];
                r[DW + l] = par[l];
            end
        end
        return r;
    endfunction

    always_comb begin
        selected = !chip_select_a_n && chip_select_b && !chip_select_c_n;
        // a full queue holds off the edge that would capture data
        recognized = !clock_qualifier_n && !(pend_q && !fifo_in_ready);
        load = recognized && !advance_load_n;
        // an advance with nothing in progress is ignored
        advance = recognized && advance_load_n &&
            (op_q != ftb_pkg::FTB_OP_DESEL);
        access = (load && selected) || advance;
        next_step = step_q + ftb_pkg::STEP_ONE;
        // advances keep the upper bits and step only the low two
        if (load) begin
            acc_addr = address;
        end else begin
            acc_addr = {base_q[ADDR_W-1:BW],
                burst_low(base_q[BW-1:0], next_step, order_sync)};
        end

        // data of the last write access is taken on this edge
        fifo_in_valid = pend_q && !clock_qualifier_n;
        push_entry.addr = pend_addr_q;
        push_entry.parity = parity_lines_in;
        push_entry.data = data_in;
        push_entry.lane_n = pend_lane_q;
        // one entry leaves per edge, so the queue holds one at most
        fifo_out_ready = !clock_qualifier_n;

        // newest data wins: array, then queued head, then this capture
        merged = array_word;
        if (fifo_out_valid && head_entry.addr == acc_addr) begin
            merged = lane_merge(merged, head_entry.data,
                head_entry.parity, head_entry.lane_n);
        end
        if (fifo_in_valid && pend_addr_q == acc_addr) begin
            merged = lane_merge(merged, data_in, parity_lines_in,
                pend_lane_q);
        end
    end

    always_comb begin
        op_d = op_q;
        base_d = base_q;
        step_d = step_q;
        pend_d = pend_q;
        pend_addr_d = pend_addr_q;
        pend_lane_d = pend_lane_q;
        rd_d = rd_q;
        rdata_d = rdata_q;
        // only a load samples the selects and the write strobe
        if (load) begin
            if (selected) begin
                base_d = address;
                step_d = ftb_pkg::STEP_RESET;
                if (write_n) begin
                    op_d = ftb_pkg::FTB_OP_READ;
                end else begin
                    op_d = ftb_pkg::FTB_OP_WRITE;
                end
            end else begin
                op_d = ftb_pkg::FTB_OP_DESEL;
            end
        end else if (advance) begin
            step_d = next_step;
        end
        if (recognized) begin
            // every recognized edge closes the last access and opens one if it loads selected or advances
            pend_d = 1'b0;
            rd_d = 1'b0;
            case (op_d)
                ftb_pkg::FTB_OP_READ: begin
                    if (access) begin
                        rd_d = 1'b1;
                        rdata_d = merged;
                    end
                end
                ftb_pkg::FTB_OP_WRITE: begin
                    if (access) begin
                        pend_d = 1'b1;
                        pend_addr_d = acc_addr;
                        pend_lane_d = byte_lane_select_n;
                    end
                end
                ftb_pkg::FTB_OP_DESEL: begin
                    rd_d = 1'b0;
                end
                default: begin
                    rd_d = 1'b0;
                end
            endcase
        end
        // output enable acts even while the clock is suspended
        drive_d = rd_d && !oe_n_sync;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            op_q <= ftb_pkg::FTB_OP_DESEL;
            base_q <= '0;
            step_q <= ftb_pkg::STEP_RESET;
            pend_q <= 1'b0;
            pend_addr_q <= '0;
            pend_lane_q <= '1;
            rd_q <= 1'b0;
            rdata_q <= '0;
            drive_q <= 1'b0;
        end else begin
            op_q <= op_d;
            base_q <= base_d;
            step_q <= step_d;
            pend_q <= pend_d;
            pend_addr_q <= pend_addr_d;
            pend_lane_q <= pend_lane_d;
            rd_q <= rd_d;
            rdata_q <= rdata_d;
            drive_q <= drive_d;
        end
    end

    // each byte lane keeps its own array, parity bit above the byte,
    // so lanes are written independently and unselected ones untouched
    generate
        for (genvar l = 0; l < LN; l++) begin : g_lane
            // contents are not cleared by reset
            logic [LW:0] lane_mem [0:WORDS-1];

            always_ff @(posedge clk) begin
                if (fifo_out_valid && fifo_out_ready &&
                    !head_entry.lane_n[l]) begin
                    lane_mem[head_entry.addr] <= {head_entry.parity[l],
                        head_entry.data[l*LW +: LW]};
                end
            end

            assign array_word[l*LW +: LW] = lane_mem[acc_addr][LW-1:0];
            assign array_word[DW + l] = lane_mem[acc_addr][LW];
        end
    endgenerate

    // pins come straight from registers
    assign data_out = rdata_q[DW-1:0];
    assign parity_lines_out = rdata_q[WW-1:DW];
    assign data_oe = drive_q;
    assign parity_lines_oe = drive_q;

endmodule

// file: core/ftb_sync.sv
`timescale 1ns/1ps
module ftb_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    logic [W-1:0] out_d;

    // a change counts once the second and third stages agree
    always_comb begin
        out_d = out_q;
        if (s2_q == s3_q) begin
            out_d = s2_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            out_q <= RESET_VAL;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign q = out_q;

endmodule

// file: include/ftb_pkg.sv
package ftb_pkg;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int LANES = 2;
    localparam int LANE_W = 8;
    localparam int BURST_W = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int WORD_W = DATA_W + LANES;

    // values after reset, and the burst step size
    localparam logic OE_N_RESET = 1'h1;
    localparam logic ORDER_RESET = 1'h1;
    localparam logic [BURST_W-1:0] STEP_RESET = 2'h0;
    localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;

    typedef enum logic [1:0] {
        FTB_OP_DESEL = 2'b00,
        FTB_OP_READ = 2'b01,
        FTB_OP_WRITE = 2'b10
    } ftb_op_t;

    // one completed write on its way to the array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] parity;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] lane_n;
    } ftb_wr_t;

    localparam int WR_W = ADDR_W + DATA_W + 2 * LANES;

endpackage

// file: test/flow_through_burst_sram_port_tb_top.sv
`timescale 1ns/1ps
module flow_through_burst_sram_port_tb_top;
    localparam logic [2:0] SEL = 3'h2;
    localparam logic [2:0] OFF = 3'h6;
    localparam logic [17:0] A = 18'h12345;
    localparam logic [17:0] B = 18'h2AB41;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [17:0] mem [logic [17:0]];
    logic clock_qualifier_n, chip_select_a_n, chip_select_b, chip_select_c_n;
    logic advance_load_n, write_n, output_enable_n, burst_order;
    logic data_oe, parity_lines_oe;
    logic [1:0] byte_lane_select_n, parity_lines_in, parity_lines_out;
    logic [17:0] address;
    logic [15:0] data_in, data_out;
    ftb_port #(.ADDR_W(18), .FIFO_DEPTH(16)) i_dut (.*);
    ftb_host i_host (.*);
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_out(input logic [17:0] exp);
        #1 checks_done++;
        if ({parity_lines_out, data_out} !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time,
                {parity_lines_out, data_out}, exp);
        end
    endtask
    task automatic chk_oe(input logic exp);
        #1 checks_done++;
        if (data_oe !== exp || parity_lines_oe !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, data_oe, exp);
        end
    endtask
    // expected array contents, nine mask bits (byte and parity) per written lane
    task automatic wm(input logic [17:0] a, input logic [17:0] d,
        input logic [1:0] ln);
        logic [17:0] m;
        m = {~ln, {8{~ln[1]}}, {8{~ln[0]}}};
        mem[a] = ((mem.exists(a) ? mem[a] : 18'h0) & ~m) | (d & m);
    endtask
    function automatic logic [17:0] nxt(input logic [17:0] a,
        input logic [1:0] k, input logic ord);
        return {a[17:2], ord ? a[1:0] ^ k : a[1:0] + k};
    endfunction
    task automatic ld_wr(input logic [17:0] a, input logic [1:0] ln,
        input logic dv, input logic [17:0] d);
        i_host.cyc(1'b0, SEL, 1'b0, 1'b0, ln, a, dv, d);
    endtask
    task automatic ld_rd(input logic [17:0] a);
        i_host.cyc(1'b0, SEL, 1'b0, 1'b1, 2'h3, a, 1'b1, 18'h15555);
    endtask
    // selects, strobe and address deliberately wrong on advances
    task automatic adv(input logic dv, input logic [17:0] d);
        i_host.cyc(1'b0, OFF, 1'b1, 1'b0, 2'h0, 18'h3FFFF, dv, d);
    endtask
    task automatic desel(input logic [2:0] cs, input logic [17:0] d);
        i_host.cyc(1'b0, cs, 1'b0, 1'b1, 2'h3, 18'h0, 1'b1, d);
    endtask
    task automatic susp();
        i_host.cyc(1'b1, SEL, 1'b0, 1'b0, 2'h0, 18'h0, 1'b0, 18'h0);
    endtask
    task automatic t_lanes();
        ld_wr(A, 2'h0, 1'b0, 18'h0);
        susp();
        ld_wr(A, 2'h2, 1'b1, 18'h3A55A);
        chk_oe(1'b0);
        ld_wr(A, 2'h3, 1'b1, 18'h0C3C3);
        ld_rd(A);
        wm(A, 18'h3A55A, 2'h0);
        wm(A, 18'h0C3C3, 2'h2);
        wm(A, 18'h15555, 2'h3);
        desel(OFF, 18'h0);
        chk_out(mem[A]);
        chk_oe(1'b1);
        desel(OFF, 18'h0);
        chk_oe(1'b0);
    endtask
    task automatic t_burst(input logic ord);
        i_host.mode(1'b0, ord);
        ld_wr(B, 2'h0, 1'b0, 18'h0);
        for (int k = 0; k < 4; k++) begin
            wm(nxt(B, k[1:0], ord), {16'hB000, k[1:0]}, 2'h0);
            if (k < 3) adv(1'b1, {16'hB000, k[1:0]});
            else desel(OFF, 18'h2C003);
        end
        ld_rd(B);
        for (int k = 0; k < 5; k++) begin
            if (k == 2) begin
                susp();
                chk_out(mem[nxt(B, 2'h2, ord)]);
            end
            if (k < 4) adv(1'b0, 18'h0);
            else desel(OFF, 18'h0);
            chk_out(mem[nxt(B, k[1:0], ord)]);
        end
        ld_rd(nxt(B, 2'h3, ord));
        desel(OFF, 18'h0);
        chk_out(mem[nxt(B, 2'h3, ord)]);
    endtask
    task automatic t_desel();
        logic [2:0] cs [3] = '{3'h6, 3'h0, 3'h3};
        foreach (cs[i]) begin
            ld_rd(A);
            desel(cs[i], 18'h0);
            chk_oe(1'b1);
            adv(1'b0, 18'h0);
            chk_oe(1'b0);
            desel(OFF, 18'h0);
            chk_oe(1'b0);
        end
    endtask
    task automatic t_oe();
        i_host.mode(1'b1, 1'b1);
        ld_rd(A);
        desel(OFF, 18'h0);
        chk_out(mem[A]);
        chk_oe(1'b0);
        i_host.mode(1'b0, 1'b1);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        chk_oe(1'b0);
        i_host.mode(1'b0, 1'b1);
        t_lanes();
        t_burst(1'b0);
        t_burst(1'b1);
        t_desel();
        t_oe();
        print_verdict();
    end
endmodule

// file: test/ftb_host.sv
`timescale 1ns/1ps
module ftb_host (
    input wire logic clk,
    output logic clock_qualifier_n,
    output logic chip_select_a_n,
    output logic chip_select_b,
    output logic chip_select_c_n,
    output logic advance_load_n,
    output logic write_n,
    output logic [1:0] byte_lane_select_n,
    output logic [17:0] address,
    output logic output_enable_n,
    output logic burst_order,
    output logic [15:0] data_in,
    output logic [1:0] parity_lines_in,
    input wire logic [15:0] data_out,
    input wire logic data_oe,
    input wire logic [1:0] parity_lines_out
);
    logic drv = 1'b0;
    logic [17:0] wd = 18'h0;
    logic [17:0] last = 18'h0;
    initial begin
        clock_qualifier_n = 1'b0;
        {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h6;
        advance_load_n = 1'b0;
        write_n = 1'b1;
        byte_lane_select_n = 2'h3;
        address = 18'h0;
        output_enable_n = 1'b1;
        burst_order = 1'b1;
    end
    // shared line: device, then host, else a released line that toggles
    always_comb begin
        if (data_oe) begin
            {parity_lines_in, data_in} = {parity_lines_out, data_out};
        end else begin
            {parity_lines_in, data_in} = drv ? wd : ~last;
        end
    end
    always @(posedge clk) begin
        last <= {parity_lines_in, data_in};
    end
    task automatic cyc(input logic cqn, input logic [2:0] cs,
        input logic adv, input logic wrn, input logic [1:0] ln,
        input logic [17:0] a, input logic dv, input logic [17:0] d);
        @(posedge clk);
        clock_qualifier_n <= cqn;
        {chip_select_a_n, chip_select_b, chip_select_c_n} <= cs;
        advance_load_n <= adv;
        write_n <= wrn;
        byte_lane_select_n <= ln;
        address <= a;
        drv <= dv;
        wd <= d;
    endtask
    task automatic mode(input logic oen, input logic ord);
        @(posedge clk);
        output_enable_n <= oen;
        burst_order <= ord;
        repeat (6) @(posedge clk);
    endtask
endmodule

// file: test/ftb_port_asserts.sv
`timescale 1ns/1ps
module ftb_port_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clock_qualifier_n,
    input wire logic chip_select_a_n,
    input wire logic chip_select_b,
    input wire logic chip_select_c_n,
    input wire logic advance_load_n,
    input wire logic write_n,
    input wire logic output_enable_n,
    input wire logic [ftb_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic [ftb_pkg::LANES-1:0] parity_lines_out,
    input wire logic parity_lines_oe
);
    logic [2:0] low_q;
    logic [2:0] low_d;
    logic sel;
    logic ld;
    logic adv;
    logic rd;
    assign sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    assign ld = !clock_qualifier_n && !advance_load_n;
    assign adv = !clock_qualifier_n && advance_load_n;
    // read load once the drive enable has settled low
    assign rd = ld && sel && write_n && low_q == 3'h7;
    always_comb begin
        low_d = output_enable_n ? 3'h0 : low_q + {2'h0, low_q != 3'h7};
    end
    always_ff @(posedge clk) begin
        low_q <= resetn ? low_d : 3'h0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_suspend_hold: assert property (
        clock_qualifier_n |=> $stable({parity_lines_out, data_out}))
        else $error("word moved in suspend");
    a_desel_release: assert property (
        ld && !sel |=> !data_oe && !parity_lines_oe)
        else $error("drive after deselect");
    a_write_quiet: assert property (
        ld && sel && !write_n |=> !data_oe && !parity_lines_oe)
        else $error("drive in write");
    a_read_drive: assert property (
        rd |=> data_oe && parity_lines_oe)
        else $error("read not driven");
    a_burst_drive: assert property (
        rd ##1 adv |=> data_oe)
        else $error("read burst not driven");
    a_burst_write: assert property (
        ld && sel && !write_n ##1 adv |=> !data_oe)
        else $error("write burst driven");
    a_adv_idle: assert property (
        ld && !sel ##1 adv |=> !data_oe)
        else $error("advance after deselect drove");
    a_oe_off: assert property (
        output_enable_n [*7] |-> !data_oe)
        else $error("drive with enable high");
    c_read: cover property (rd ##1 adv);
    c_write: cover property (ld && sel && !write_n ##1 adv);
    c_susp: cover property (clock_qualifier_n ##1 !clock_qualifier_n);
endmodule
bind ftb_port ftb_port_asserts i_chk (.*);
